// file: rtl/spbf_pkg.sv
// Constants and carriers of the speech post-processing gain and bass block
package spbf_pkg;
   // ------------------------------------------------------------
   // APB register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_EMEAN = 8'h04;
   localparam logic [7:0] ADDR_GAIN = 8'h08;
   localparam logic [7:0] ADDR_ALPHA = 8'h0C;
   localparam int CTRL_K1_BIT = 0;
   localparam int CTRL_K2_BIT = 1;
   localparam logic [31:0] CTRL_MASK = 32'h0000_7F03;
   localparam logic [31:0] CTRL_RESET = 32'h0000_4000;
   // ------------------------------------------------------------
   // Subframe, history and lag limits
   // ------------------------------------------------------------
   localparam logic [6:0] SUB_LAST = 7'h3F;
   localparam logic [6:0] SUB_MAX = 7'h40;
   localparam logic [7:0] BASE_BACK = 8'h80;
   localparam logic [7:0] MAX_LAG = 8'h40;
   localparam logic [7:0] MIN_LAG = 8'h02;
   localparam logic [7:0] LAG_TOL = 8'h03;
   // ------------------------------------------------------------
   // Fixed-point weights
   // ------------------------------------------------------------
   localparam logic [17:0] G_ONE = 18'h04000;
   localparam logic [17:0] G_MAX = 18'h3FFFF;
   localparam logic [17:0] NB_OLD = 18'h03F33;
   localparam logic [17:0] NB_NEW = 18'h000CD;
   localparam logic [17:0] SWB_OLD = 18'h03666;
   localparam logic [17:0] SWB_NEW = 18'h0099A;
   localparam logic [17:0] ALPHA_MAX = 18'h04000;
   localparam logic signed [17:0] EMPH = 18'sh07333;
   localparam logic signed [17:0] EMEAN_OLD = 18'sh0FD71;
   localparam logic signed [17:0] EMEAN_NEW = 18'sh0028F;
   localparam logic signed [17:0] OCT_PER_DB = 18'sh00055;
   localparam logic [15:0] DB_PER_OCT = 16'h0303;
   localparam logic [31:0] STAB_CUR = 32'h0000_6666;
   localparam logic [31:0] STAB_OLD = 32'h0000_199A;
   localparam logic [31:0] STAB_SQRT = 32'h0000_1333;
   localparam logic signed [19:0] STAB_ONE = 20'sh08000;
   localparam logic signed [55:0] RATIO_MAX = 56'sh7FFFF;
   localparam logic [9:0] RATE_MAX = 10'h140;
   localparam logic [9:0] RATE_A = 10'h0A4;
   localparam logic [9:0] RATE_B = 10'h0F4;
   localparam logic [7:0] NOISE_MAX = 8'h14;
   localparam logic [3:0][15:0] ADJ_TAB = {16'h1000, 16'h2000, 16'h3000, 16'h4000};
   localparam logic [5:0] LP_FULL_BINS = 6'h04;
   localparam logic signed [17:0] W_FULL = 18'sh07FFF;
   localparam logic signed [17:0] W_EDGE = 18'sh04000;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_COLL = 3'h0, ST_TRACK = 3'h1, ST_CORR = 3'h3, ST_RATIO = 3'h2,
      ST_ERR = 3'h6, ST_ENER = 3'h7, ST_OUT = 3'h5
   } spbf_st_t;
   typedef struct packed {
      logic signed [15:0] pre;
      logic signed [15:0] post;
      logic signed [15:0] dec;
   } spbf_smp_t;
   typedef struct packed {
      logic [7:0] lag;
      logic onset;
      logic nb;
      logic swb;
      logic lp_mode;
      logic [9:0] rate;
      logic [7:0] noise;
      logic [15:0] stab;
      logic [1:0] adj;
   } spbf_sub_t;
   typedef struct packed {
      logic signed [15:0] out;
      logic signed [15:0] enh;
   } spbf_res_t;
   typedef struct packed {
      logic [5:0] bin;
      logic signed [15:0] enh_re;
      logic signed [15:0] enh_im;
      logic signed [15:0] dec_re;
      logic signed [15:0] dec_im;
   } spbf_bin_t;
   typedef struct packed {
      logic [5:0] bin;
      logic signed [15:0] re;
      logic signed [15:0] im;
   } spbf_fdo_t;
   typedef struct packed {
      spbf_st_t st;
      logic [6:0] cnt;
      logic [7:0] wp;
      logic [7:0] base;
      logic [7:0] lag;
      spbf_sub_t sub;
      spbf_sub_t subp;
      logic [22:0] spre;
      logic [22:0] spost;
      logic [17:0] fg;
      logic [17:0] g;
      logic [15:0] ths;
      logic en;
      logic rdy;
      logic ov;
      logic signed [39:0] cp;
      logic signed [39:0] ep;
      logic signed [19:0] ratio;
      logic [17:0] alpha;
      logic signed [31:0] epp;
      logic [63:0] esum;
      logic signed [17:0] emean;
      spbf_res_t res;
   } spbf_dp_t;
endpackage

// file: rtl/spbf_top.sv
// Adaptive gain control and bass post-filter pitch enhancer
// Operation
// - Gain factor is sum of |pre| over sum of |post| for 64 samples.
// - Per-sample smoothed gain scales post samples; narrow or superwide weights.
// - Gain starts at 1.0 and carries over from the last sample.
// - Narrow band output carries the gain-scaled post-filtered signal.
// - Bass filter on for LP modes to 32 kbit/s, off for noisy narrowband.
// - Enhancement signal is enhancer output minus decoded signal, sent onward.
// - Enhancement bins weighted by low-pass response and added to decoded bins.
// - Enhancer output mixes decoded and predicted sample by attenuation coefficient.
// - Prediction is half past plus half future sample one pitch apart.
// - Pitch period is the received closed-loop lag of the subframe.
// - Voiced onset uses the lag of the following subframe.
// - Lag tracker halves doublings and smooths the contour.
// - Correlation and prediction energy summed over the subframe.
// - Coefficient is k1 times correlation over energy plus noise floor, clamped.
// - Prediction error is k2 times sample minus ratio times prediction.
// - Error is emphasised by adding 0.9 of the previous emphasised value.
// - Emphasised error energy is converted to decibels.
// - Mean error energy tracks 0.99 old plus 0.01 new, zero after reset.
// - Smoothed stability is 0.8 current plus 0.2 previous.
// - Coefficient scaled by stationarity term from stability and its change.
// - At 16.4 and 24.4 kbit/s coefficient scaled by 2-bit gain adjustment.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module spbf_top (
   // Clock and reset
   input logic CLK,
   input logic RESET,
   // APB slave
   input logic PSEL,
   input logic PENABLE,
   input logic PWRITE,
   input logic [7:0] PADDR,
   input logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Sample stream from decoder core
   input logic IN_VALID,
   input spbf_pkg::spbf_smp_t IN_SMP,
   input spbf_pkg::spbf_sub_t IN_SUB,
   output logic IN_READY,
   // Sample stream to de-emphasis and filter-bank analysis
   output logic OUT_VALID,
   output spbf_pkg::spbf_res_t OUT_RES,
   // Filter-bank bins
   input logic BIN_VALID,
   input spbf_pkg::spbf_bin_t BIN_IN,
   output logic BIN_OUT_VALID,
   output spbf_pkg::spbf_fdo_t BIN_OUT
);
   import spbf_pkg::*;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic signed [15:0] sat16(input logic signed [47:0] x);
      if (x > 48'sh7FFF) return 16'sh7FFF;
      if (x < -48'sh8000) return -16'sh8000;
      return x[15:0];
   endfunction

   function automatic logic [15:0] absv(input logic signed [15:0] v);
      return (v < 0) ? 16'(-v) : 16'(v);
   endfunction

   // Log2 in Q8: leading-one position plus linear fraction
   function automatic logic [15:0] log2q8(input logic [63:0] x);
      logic [5:0] p;
      logic [63:0] y;
      p = '0;
      for (int i = 0; i < 64; i++) begin
         if (x[i]) p = 6'(i);
      end
      y = x << (6'h3F - p);
      return {2'b00, p, y[62:55]};
   endfunction

   // Power of two of a Q8 exponent, linear between octaves
   function automatic logic [47:0] pow2q8(input logic signed [17:0] x);
      logic [47:0] m;
      if (x < 0) return 48'h1;
      if (x[17:8] > 10'h026) return 48'h4000_0000_0000;
      m = {39'h0, 1'b1, x[7:0]};
      return (m << x[13:8]) >> 8;
   endfunction

   function automatic logic [15:0] isqrt(input logic [31:0] x);
      logic [15:0] r;
      logic [15:0] t;
      r = '0;
      for (int i = 15; i >= 0; i--) begin
         t = r | (16'h1 << i);
         if (32'(t) * 32'(t) <= x) r = t;
      end
      return r;
   endfunction

   function automatic logic signed [17:0] lp_resp(input logic [5:0] k);
      if (k < LP_FULL_BINS) return W_FULL;
      if (k == LP_FULL_BINS) return W_EDGE;
      return '0;
   endfunction

   // ------------------------------------------------------------
   // APB registers
   // ------------------------------------------------------------
   spbf_dp_t dr, dn;
   logic [31:0] ctrl_reg, ctrl_next, rdata_reg, rdata_next;
   logic rdy_reg, rdy_next, err_reg, err_next;
   logic [6:0] sub_len;

   always_comb begin
      ctrl_next = ctrl_reg;
      rdata_next = rdata_reg;
      rdy_next = PSEL && PENABLE && !rdy_reg;
      err_next = 1'b0;
      if (PSEL && PENABLE && !rdy_reg) begin
         case (PADDR)
            ADDR_CTRL: rdata_next = ctrl_reg;
            ADDR_EMEAN: rdata_next = 32'(dr.emean);
            ADDR_GAIN: rdata_next = {14'h0, dr.g};
            ADDR_ALPHA: rdata_next = {14'h0, dr.alpha};
            default: begin
               rdata_next = '0;
               err_next = 1'b1;
            end
         endcase
      end
      // Write lands on the edge that completes the transfer
      if (PSEL && PENABLE && rdy_reg && PWRITE && PADDR == ADDR_CTRL) begin
         ctrl_next = PWDATA & CTRL_MASK;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ctrl_reg <= CTRL_RESET;
         rdata_reg <= '0;
         rdy_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
         rdy_reg <= rdy_next;
         err_reg <= err_next;
      end
   end

   assign PRDATA = rdata_reg;
   assign PREADY = rdy_reg;
   assign PSLVERR = err_reg;
   assign sub_len = (ctrl_reg[14:8] > SUB_MAX) ? SUB_MAX : ctrl_reg[14:8];

   // ------------------------------------------------------------
   // Sample memories
   // ------------------------------------------------------------
   // History spans one subframe behind plus a lag either side, so the
   // future sample of the prediction is always already stored.
   logic signed [15:0] post_mem [64];
   logic signed [15:0] pre_mem [64];
   logic signed [15:0] hist [256];
   logic mem_we;

   always_ff @(posedge CLK) begin
      if (mem_we) begin
         post_mem[dr.cnt[5:0]] <= IN_SMP.post;
         pre_mem[dr.cnt[5:0]] <= IN_SMP.pre;
         hist[dr.wp] <= IN_SMP.dec;
      end
   end

   // ------------------------------------------------------------
   // Subframe datapath
   // ------------------------------------------------------------
   always_comb begin
      logic [7:0] n;
      logic [7:0] l;
      logic [7:0] lp2;
      logic signed [16:0] ab;
      logic signed [15:0] s;
      logic signed [15:0] sp;
      logic signed [55:0] q;
      logic [55:0] u;
      logic signed [47:0] t;
      logic [47:0] den;
      logic signed [31:0] e;
      logic signed [17:0] edb;
      logic signed [19:0] term;
      logic [15:0] dv;
      logic [17:0] al;
      logic [17:0] gw;
      dn = dr;
      dn.ov = 1'b0;
      mem_we = 1'b0;
      l = '0;
      lp2 = '0;
      q = '0;
      u = '0;
      t = '0;
      den = '0;
      e = '0;
      edb = '0;
      term = '0;
      dv = '0;
      al = '0;
      gw = '0;
      n = dr.base + {1'b0, dr.cnt};
      s = hist[n];
      ab = 17'(hist[n - dr.lag]) + 17'(hist[n + dr.lag]);
      sp = ab[16:1];
      case (dr.st)
         ST_COLL: begin
            if (IN_VALID && dr.rdy) begin
               mem_we = 1'b1;
               dn.spre = dr.spre + 23'(absv(IN_SMP.pre));
               dn.spost = dr.spost + 23'(absv(IN_SMP.post));
               if (dr.cnt == '0) begin
                  dn.sub = IN_SUB;
                  dn.subp = dr.sub;
               end
               dn.wp = dr.wp + 8'h01;
               dn.cnt = dr.cnt + 7'h01;
               if (dr.cnt == SUB_LAST) begin
                  dn.cnt = '0;
                  dn.rdy = 1'b0;
                  dn.st = ST_TRACK;
               end
            end
         end
         ST_TRACK: begin
            // lag of the subframe, or the next one at onset
            l = dr.subp.onset ? dr.sub.lag : dr.subp.lag;
            lp2 = {dr.lag[6:0], 1'b0};
            if (dr.lag != '0 && l + LAG_TOL >= lp2 && l <= lp2 + LAG_TOL) l = l >> 1;
            if (l > {MAX_LAG[6:0], 1'b0}) l = l >> 2;
            else if (l > MAX_LAG) l = l >> 1;
            if (dr.lag != '0 && l <= dr.lag + LAG_TOL && dr.lag <= l + LAG_TOL) begin
               l = 8'((9'(l) + 9'(dr.lag) + 9'h001) >> 1);
            end
            if (l < MIN_LAG) l = MIN_LAG;
            dn.lag = l;
            dn.base = dr.wp - BASE_BACK;
            // gain factor, unity when the post sum is empty
            u = 56'({dr.spre, 14'h0000});
            if (dr.spost == '0) dn.fg = G_ONE;
            else begin
               u = u / 56'(dr.spost);
               dn.fg = (u > 56'(G_MAX)) ? G_MAX : u[17:0];
            end
            dn.ths = 16'((STAB_CUR * 32'(dr.subp.stab) + STAB_OLD * 32'(dr.ths)) >> 15);
            dn.en = dr.subp.lp_mode && dr.subp.rate <= RATE_MAX
                    && !(dr.subp.nb && dr.subp.noise > NOISE_MAX);
            dn.spre = '0;
            dn.spost = '0;
            dn.cp = '0;
            dn.ep = '0;
            dn.st = ST_CORR;
         end
         ST_CORR: begin
            dn.cp = dr.cp + 40'(s * sp);
            dn.ep = dr.ep + 40'(sp * sp);
            dn.cnt = dr.cnt + 7'h01;
            if (dr.cnt + 7'h01 >= sub_len) begin
               dn.cnt = '0;
               dn.st = ST_RATIO;
            end
         end
         ST_RATIO: begin
            dn.ratio = '0;
            if (dr.ep != '0) begin
               q = (56'(dr.cp) <<< 14) / 56'(dr.ep);
               if (q > RATIO_MAX) dn.ratio = RATIO_MAX[19:0];
               else if (q < -RATIO_MAX) dn.ratio = -RATIO_MAX[19:0];
               else dn.ratio = q[19:0];
            end
            // coefficient against energy plus error floor
            den = 48'(dr.ep) + pow2q8(18'((36'(dr.emean) * 36'(OCT_PER_DB)) >>> 8));
            q = (56'(dr.cp) <<< (ctrl_reg[CTRL_K1_BIT] ? 15 : 14)) / signed'(56'(den));
            if (q < 0) dn.alpha = '0;
            else if (q > signed'(56'(ALPHA_MAX))) dn.alpha = ALPHA_MAX;
            else dn.alpha = q[17:0];
            dn.epp = '0;
            dn.esum = '0;
            dn.st = ST_ERR;
         end
         ST_ERR: begin
            t = (ctrl_reg[CTRL_K2_BIT] ? (48'(s) <<< 14) : 48'(dr.ratio) * 48'(s))
                - 48'(dr.ratio) * 48'(sp);
            e = 32'(t >>> 14) + 32'((48'(dr.epp) * 48'(EMPH)) >>> 15);
            dn.epp = e;
            dn.esum = dr.esum + 64'(64'(e) * 64'(e));
            dn.cnt = dr.cnt + 7'h01;
            if (dr.cnt + 7'h01 >= sub_len) begin
               dn.cnt = '0;
               dn.st = ST_ENER;
            end
         end
         ST_ENER: begin
            if (dr.esum != '0) edb = 18'((32'(log2q8(dr.esum)) * 32'(DB_PER_OCT)) >> 8);
            dn.emean = 18'((36'(dr.emean) * 36'(EMEAN_OLD) + 36'(edb) * 36'(EMEAN_NEW)) >>> 16);
            dv = (dr.ths >= dr.subp.stab) ? dr.ths - dr.subp.stab : dr.subp.stab - dr.ths;
            term = STAB_ONE + 20'((32'(isqrt(32'({dr.subp.stab, 15'h0000}))) * STAB_SQRT) >> 15)
                   - 20'({dv, 1'b0});
            if (term < 0) term = '0;
            al = 18'((38'(dr.alpha) * 38'(unsigned'(term))) >> 15);
            if (dr.subp.rate == RATE_A || dr.subp.rate == RATE_B) begin
               al = 18'((34'(al) * 34'(ADJ_TAB[dr.subp.adj])) >> 14);
            end
            dn.alpha = dr.en ? al : '0;
            dn.st = ST_OUT;
         end
         ST_OUT: begin
            // gain recursion carries over between subframes
            if (dr.sub.swb) begin
               gw = 18'((36'(dr.g) * 36'(SWB_OLD) + 36'(dr.fg) * 36'(SWB_NEW)) >> 14);
            end else begin
               gw = 18'((36'(dr.g) * 36'(NB_OLD) + 36'(dr.fg) * 36'(NB_NEW)) >> 14);
            end
            dn.g = gw;
            // scaled post signal goes to de-emphasis for nb or swb, unscaled pre signal otherwise
            if (dr.sub.nb || dr.sub.swb) begin
               dn.res.out = sat16((signed'(48'(gw)) * 48'(post_mem[dr.cnt[5:0]])) >>> 14);
            end else begin
               dn.res.out = pre_mem[dr.cnt[5:0]];
            end
            dn.res.enh = sat16((signed'(48'(dr.alpha)) * (48'(sp) - 48'(s))) >>> 15);
            dn.ov = 1'b1;
            dn.cnt = dr.cnt + 7'h01;
            if (dr.cnt == SUB_LAST) begin
               dn.cnt = '0;
               dn.rdy = 1'b1;
               dn.st = ST_COLL;
            end
         end
         default: begin
            dn.st = ST_COLL;
            dn.cnt = '0;
            dn.rdy = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         dr <= '0;
         dr.g <= G_ONE;
         dr.rdy <= 1'b1;
      end else begin
         dr <= dn;
      end
   end

   assign IN_READY = dr.rdy;
   assign OUT_VALID = dr.ov;
   assign OUT_RES = dr.res;

   // ------------------------------------------------------------
   // Low-band mixing of filter-bank bins
   // ------------------------------------------------------------
   logic bv_reg, bv_next;
   spbf_fdo_t bo_reg, bo_next;

   always_comb begin
      logic signed [17:0] w;
      w = lp_resp(BIN_IN.bin);
      bo_next = bo_reg;
      bv_next = BIN_VALID;
      if (BIN_VALID) begin
         // low-pass weighted enhancement added to decoded bins
         bo_next.bin = BIN_IN.bin;
         bo_next.re = sat16(48'(BIN_IN.dec_re) + ((48'(w) * 48'(BIN_IN.enh_re)) >>> 15));
         bo_next.im = sat16(48'(BIN_IN.dec_im) + ((48'(w) * 48'(BIN_IN.enh_im)) >>> 15));
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         bv_reg <= 1'b0;
         bo_reg <= '0;
      end else begin
         bv_reg <= bv_next;
         bo_reg <= bo_next;
      end
   end

   assign BIN_OUT_VALID = bv_reg;
   assign BIN_OUT = bo_reg;
endmodule

// file: verif/spbf_checker.sv
// Port-level checker for the gain and bass post-processing block
`timescale 1ns/1ps
module spbf_checker (
   // Clock and reset
   input logic CLK,
   input logic RESET,
   // APB
   input logic PSEL,
   input logic PENABLE,
   input logic PREADY,
   // Sample streams
   input logic IN_VALID,
   input logic IN_READY,
   input logic OUT_VALID,
   // Filter-bank bins
   input logic BIN_VALID,
   input spbf_pkg::spbf_bin_t BIN_IN,
   input logic BIN_OUT_VALID,
   input spbf_pkg::spbf_fdo_t BIN_OUT
);
   import spbf_pkg::*;
   logic [5:0] tk_reg, tk_next;
   logic [6:0] run_reg, run_next;
   always_comb begin
      tk_next = tk_reg + {5'h00, IN_VALID & IN_READY};
      run_next = OUT_VALID ? run_reg + 7'h01 : 7'h00;
   end
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         tk_reg <= 6'h00;
         run_reg <= 7'h00;
      end else begin
         tk_reg <= tk_next;
         run_reg <= run_next;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_last;
      IN_VALID && IN_READY && tk_reg == 6'h3F;
   endsequence
   sequence s_first_out;
      OUT_VALID && run_reg == 7'h00;
   endsequence
   a_sub_close: assert property (s_last |=> !IN_READY)
      else $error("input open after 64 samples");
   // First output pulse is registered 2*len+4 edges on, so it is sampled one edge later
   a_first_out: assert property (s_last |-> ##133 s_first_out)
      else $error("first output off time");
   a_burst_len: assert property ($fell(OUT_VALID) |-> run_reg == 7'h40)
      else $error("output burst not 64");
   a_ready_back: assert property ($rose(IN_READY) |-> OUT_VALID && run_reg == 7'h3F)
      else $error("input reopened off time");
   a_bin_answer: assert property (
      BIN_VALID |=> BIN_OUT_VALID && BIN_OUT.bin == $past(BIN_IN.bin))
      else $error("bin answer missing");
   a_bin_idle: assert property (!BIN_VALID |=> !BIN_OUT_VALID)
      else $error("spurious bin output");
   a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("apb answer late");
   a_apb_pulse: assert property (PREADY |=> !PREADY)
      else $error("apb ready held");
endmodule
bind spbf_top spbf_checker u_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
   .PREADY(PREADY), .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID),
   .BIN_VALID(BIN_VALID), .BIN_IN(BIN_IN), .BIN_OUT_VALID(BIN_OUT_VALID), .BIN_OUT(BIN_OUT));

// file: verif/spbf_src.sv
// Decoder-core model offering one subframe of samples per start pulse
`timescale 1ns/1ps
module spbf_src (
   // Clock and reset
   input logic CLK,
   input logic RESET,
   // Bench control
   input logic start,
   input logic dbl,
   input spbf_pkg::spbf_sub_t sub,
   // Sample stream
   input logic IN_READY,
   output logic IN_VALID,
   output spbf_pkg::spbf_smp_t IN_SMP,
   output spbf_pkg::spbf_sub_t IN_SUB
);
   import spbf_pkg::*;
   logic v = 1'b0;
   logic [6:0] n = 7'h00;
   spbf_smp_t s;
   always @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         v <= 1'b0;
      end else if (start) begin
         v <= 1'b1;
         n <= 7'h00;
      end else if (v && IN_READY) begin
         v <= n != 7'h3F;
         n <= n + 7'h01;
      end
   end
   // Period three against lag two keeps the prediction off the sample
   always_comb begin
      s.post = 16'h0400 + {9'h000, n};
      s.pre = dbl ? s.post <<< 1 : s.post;
      s.dec = (n % 7'h03 == 7'h02) ? 16'h0000 : 16'h2000;
   end
   assign IN_VALID = v;
   // Idle lines show the inverse so stale data never passes as valid
   assign IN_SMP = v ? s : ~s;
   assign IN_SUB = v ? sub : ~sub;
endmodule

// file: verif/spbf_top_bench.sv
// Self-checking bench for the gain and bass post-processing block
`timescale 1ns/1ps
module spbf_top_bench;
   import spbf_pkg::*;
   logic CLK = 1'b0;
   logic RESET = 1'b1;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, BIN_VALID = 1'b0, start = 1'b0, dbl = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [31:0] PRDATA, rd;
   logic PREADY, PSLVERR, IN_VALID, IN_READY, OUT_VALID, BIN_OUT_VALID, err;
   spbf_smp_t IN_SMP;
   spbf_sub_t IN_SUB, sub = '0, cs;
   spbf_res_t OUT_RES, res [64];
   spbf_bin_t BIN_IN = '0;
   spbf_fdo_t BIN_OUT, bo [3];
   logic [5:0] bn [3] = '{6'h04, 6'h05, 6'h0A};
   logic [31:0] al [4] = '{32'h4000, 32'h1000, 32'h2000, 32'h4000};
   int n_errors = 0, samples_checked = 0, cyc = 0, k = 0, bk = 0, nz;
   always #20 CLK = ~CLK;
   spbf_top u_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .IN_VALID(IN_VALID), .IN_SMP(IN_SMP), .IN_SUB(IN_SUB), .IN_READY(IN_READY),
      .OUT_VALID(OUT_VALID), .OUT_RES(OUT_RES), .BIN_VALID(BIN_VALID), .BIN_IN(BIN_IN),
      .BIN_OUT_VALID(BIN_OUT_VALID), .BIN_OUT(BIN_OUT));
   spbf_src u_src (.CLK(CLK), .RESET(RESET), .start(start), .dbl(dbl), .sub(sub),
      .IN_READY(IN_READY), .IN_VALID(IN_VALID), .IN_SMP(IN_SMP), .IN_SUB(IN_SUB));
   // ----
   // Capture and run limit
   // ----
   always @(posedge CLK) begin
      cyc++;
      if (start) begin
         k <= 0;
      end else if (OUT_VALID === 1'b1) begin
         res[k] <= OUT_RES;
         k <= k + 1;
      end
      if (BIN_OUT_VALID === 1'b1) begin
         bo[bk] <= BIN_OUT;
         bk <= bk + 1;
      end
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   function automatic spbf_sub_t mk(input logic nb, swb, lp, input logic [9:0] r,
      input logic [7:0] ns, input logic [1:0] adj);
      return '{8'h02, 1'b0, nb, swb, lp, r, ns, 16'h0000, adj};
   endfunction
   // Waits on the output count; the run limit cuts a hang
   task automatic run_sub(input logic d, input spbf_sub_t s);
      sub <= s;
      dbl <= d;
      start <= 1'b1;
      @(posedge CLK);
      start <= 1'b0;
      @(posedge CLK);
      wait (k == 64);
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (10) @(posedge CLK);
      RESET <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, CTRL_RESET);
      apb(1'b0, ADDR_GAIN, 32'h0);
      chk(rd, 32'h0000_4000);
      apb(1'b0, ADDR_EMEAN, 32'h0);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h10, 32'h0);
      chk({rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, CTRL_MASK);
      apb(1'b1, ADDR_GAIN, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h0000_4001);
      apb(1'b0, ADDR_GAIN, 32'h0);
      chk(rd, 32'h0000_4000);
      $display("register test done");
      run_sub(1'b0, mk(1'b1, 1'b0, 1'b0, 10'h140, 8'h00, 2'h0));
      for (int i = 0; i < 64; i++) begin
         chk(32'(res[i].out), 32'h0400 + i);
         chk(32'(res[i].enh), 32'h0);
      end
      apb(1'b0, ADDR_GAIN, 32'h0);
      chk(rd, 32'h0000_4000);
      run_sub(1'b1, mk(1'b0, 1'b0, 1'b0, 10'h140, 8'h00, 2'h0));
      for (int i = 0; i < 64; i++) chk(32'(res[i].out), 32'h0800 + 2 * i);
      run_sub(1'b1, mk(1'b0, 1'b1, 1'b0, 10'h140, 8'h00, 2'h0));
      chk(32'(res[0].out > 16'sh0400), 32'h1);
      apb(1'b0, ADDR_GAIN, 32'h0);
      chk(32'(rd >= 32'h7F00 && rd <= 32'h8000), 32'h1);
      run_sub(1'b0, mk(1'b0, 1'b1, 1'b0, 10'h140, 8'h00, 2'h0));
      chk(32'(res[0].out > 16'sh0600), 32'h1);
      $display("gain test done");
      // Enabled cases first, then noisy narrowband, rate above 32 and non-LP
      for (int c = 0; c < 7; c++) begin
         case (c)
            0: cs = mk(1'b0, 1'b0, 1'b1, 10'h140, 8'h00, 2'h0);
            1: cs = mk(1'b0, 1'b0, 1'b1, RATE_A, 8'h00, 2'h3);
            2: cs = mk(1'b0, 1'b0, 1'b1, RATE_B, 8'h00, 2'h2);
            3: cs = mk(1'b1, 1'b0, 1'b1, 10'h140, 8'h14, 2'h0);
            4: cs = mk(1'b1, 1'b0, 1'b1, 10'h140, 8'h15, 2'h0);
            5: cs = mk(1'b0, 1'b0, 1'b1, 10'h141, 8'h00, 2'h0);
            default: cs = mk(1'b0, 1'b0, 1'b0, 10'h140, 8'h00, 2'h0);
         endcase
         run_sub(1'b0, cs);
         run_sub(1'b0, cs);
         nz = 0;
         for (int i = 0; i < 64; i++) nz += int'(res[i].enh !== 16'h0000);
         chk(32'(nz != 0), 32'(c < 4));
         apb(1'b0, ADDR_ALPHA, 32'h0);
         if (c < 4) chk(rd, al[c]);
      end
      // Half weight leaves this pattern's two-thirds ratio below the clamp
      apb(1'b1, ADDR_CTRL, 32'h0000_4000);
      for (int r = 0; r < 2; r++) run_sub(1'b0, mk(1'b0, 1'b0, 1'b1, 10'h140, 8'h00, 2'h0));
      apb(1'b0, ADDR_ALPHA, 32'h0);
      chk(32'(rd > 32'h2000 && rd < 32'h4000), 32'h1);
      apb(1'b0, ADDR_EMEAN, 32'h0);
      chk(32'(rd != 32'h0 && !rd[17]), 32'h1);
      $display("bass test done");
      for (int i = 0; i < 3; i++) begin
         @(posedge CLK);
         BIN_VALID <= 1'b1;
         BIN_IN <= '{bn[i], 16'h1000, 16'h1000, 16'h1000, 16'hFF00};
      end
      @(posedge CLK);
      BIN_VALID <= 1'b0;
      repeat (2) @(posedge CLK);
      for (int i = 0; i < 3; i++) begin
         chk({bo[i].bin, bo[i].re}, {bn[i], (bn[i] == 6'h04) ? 16'h1800 : 16'h1000});
         chk({bo[i].bin, bo[i].im}, {bn[i], (bn[i] == 6'h04) ? 16'h0700 : 16'hFF00});
      end
      $display("bin test done");
      stop_test();
   end
endmodule
